// ### common/qelc_pkg.sv
package qelc_pkg;
    localparam int NUM_LANES = 4;
    localparam int BOOST_W = 3;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] ADDR_BOOST = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

    // boost register: one field per lane, lane n at n*stride
    localparam int BOOST_STRIDE = 4;
    localparam logic [2:0] BOOST_RESET = 3'h4;

    // status register fields
    localparam int ST_ACTIVE_POS = 0;
    localparam int ST_PRESENT_POS = 4;
    localparam int ST_FORCE_POS = 8;
    localparam int ST_ACCESS_POS = 9;
    localparam int ST_PIN_BOOST_POS = 12;
    localparam int ST_EFF_BOOST_POS = 16;

    // interrupt fields: rise of signal-present, then fall
    localparam int IRQ_RISE_POS = 0;
    localparam int IRQ_FALL_POS = 4;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // levels taken by undriven pins
    localparam logic FORCE_DEFAULT = 1'b1;
    localparam logic [2:0] PIN_BOOST_DEFAULT = 3'h4;
    localparam logic ACTIVE_DEFAULT = 1'b1;

    typedef enum logic [1:0] {
        LANE_STANDBY = 2'b00,
        LANE_NORMAL = 2'b01
    } qelc_lane_state_t;
endpackage

// ### rtl/qelc_lane.sv
`timescale 1ns/100ps
module qelc_lane (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_active,
    input wire logic i_force,
    input wire logic [qelc_pkg::BOOST_W-1:0] i_pin_boost,
    input wire logic [qelc_pkg::BOOST_W-1:0] i_reg_boost,
    input wire logic i_signal_raw,
    output logic [qelc_pkg::BOOST_W-1:0] o_boost,
    output logic o_standby,
    output logic o_present,
    output logic o_rise,
    output logic o_fall
);
    import qelc_pkg::*;

    qelc_lane_state_t state_q;
    qelc_lane_state_t state_d;
    logic [BOOST_W-1:0] boost_q;
    logic present_q;
    wire [BOOST_W-1:0] boost_d = i_force ? i_pin_boost : i_reg_boost;
    wire detect_change = i_clk_en & (i_signal_raw ^ present_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            LANE_STANDBY: begin
                if (i_active) state_d = LANE_NORMAL;
            end
            LANE_NORMAL: begin
                if (!i_active) state_d = LANE_STANDBY;
            end
            default: state_d = LANE_STANDBY;
        endcase
    end

    // detector keeps running in standby so a looped-back lane can wake
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= LANE_NORMAL;
            boost_q <= BOOST_RESET;
            present_q <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            boost_q <= boost_d;
            present_q <= i_signal_raw;
        end
    end

    assign o_boost = boost_q;
    assign o_standby = (state_q == LANE_STANDBY);
    assign o_present = present_q;
    assign o_rise = detect_change & i_signal_raw;
    assign o_fall = detect_change & ~i_signal_raw;

    // the edge that lifts reset still sees reset values, so it is skipped
    a_boost_source: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $past(i_rst_n) && $past(i_clk_en) |->
        boost_q == ($past(i_force) ? $past(i_pin_boost) : $past(i_reg_boost)))
        else $error("lane boost not from selected source");
    a_standby_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_clk_en ##1 i_clk_en |-> o_standby == !$past(i_active))
        else $error("lane standby does not follow enable");
    a_present_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $past(i_clk_en) |-> o_present == $past(i_signal_raw))
        else $error("signal present does not follow detector");
endmodule

// ### rtl/qelc_top.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module qelc_top (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // pin inputs; force, boost select and lane enables each with a flag telling whether it is driven
    input wire logic i_force_pin_boost,
    input wire logic i_force_pin_boost_drv,
    input wire logic [qelc_pkg::BOOST_W-1:0] i_boost_level_select,
    input wire logic [qelc_pkg::BOOST_W-1:0] i_boost_level_select_drv,
    input wire logic i_lane0_active_in,
    input wire logic i_lane1_active_in,
    input wire logic i_lane2_active_in,
    input wire logic i_lane3_active_in,
    input wire logic [qelc_pkg::NUM_LANES-1:0] i_lane_active_drv,
    input wire logic [qelc_pkg::NUM_LANES-1:0] i_lane_detect_raw,
    input wire logic i_reg_access_sel,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [qelc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // lane outputs
    output logic o_lane0_signal_present,
    output logic o_lane1_signal_present,
    output logic o_lane2_signal_present,
    output logic o_lane3_signal_present,
    output logic [qelc_pkg::BOOST_W-1:0] o_lane0_boost,
    output logic [qelc_pkg::BOOST_W-1:0] o_lane1_boost,
    output logic [qelc_pkg::BOOST_W-1:0] o_lane2_boost,
    output logic [qelc_pkg::BOOST_W-1:0] o_lane3_boost,
    output logic [qelc_pkg::NUM_LANES-1:0] o_lane_standby,
    output logic o_irq
);
    import qelc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    // reset is never frozen by the clock enable, otherwise it could stick
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin resolution

    wire force_pin = i_force_pin_boost_drv ? i_force_pin_boost : FORCE_DEFAULT;
    wire [BOOST_W-1:0] pin_boost =
        (i_boost_level_select & i_boost_level_select_drv) |
        (PIN_BOOST_DEFAULT & ~i_boost_level_select_drv);
    wire [NUM_LANES-1:0] active_pin = {i_lane3_active_in, i_lane2_active_in,
                                       i_lane1_active_in, i_lane0_active_in};
    wire [NUM_LANES-1:0] active_res =
        (active_pin & i_lane_active_drv) |
        ({NUM_LANES{ACTIVE_DEFAULT}} & ~i_lane_active_drv);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [NUM_LANES*BOOST_STRIDE-1:0] boost_reg_q;
    logic [2*NUM_LANES-1:0] irq_stat_q;
    logic [2*NUM_LANES-1:0] irq_mask_q;
    logic ready_q;
    logic [31:0] prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // lanes

    wire [NUM_LANES-1:0] present;
    wire [NUM_LANES-1:0] rise;
    wire [NUM_LANES-1:0] fall;
    wire [NUM_LANES*BOOST_STRIDE-1:0] eff_boost;

    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_lane
            // independent lane instances, no shared enable or detect
            qelc_lane u_lane (
                .i_core_clk(i_core_clk),
                .i_rst_n(rst_n),
                .i_clk_en(i_clk_en),
                .i_active(active_res[g]),
                .i_force(force_pin),
                .i_pin_boost(pin_boost),
                .i_reg_boost(boost_reg_q[g*BOOST_STRIDE +: BOOST_W]),
                .i_signal_raw(i_lane_detect_raw[g]),
                .o_boost(eff_boost[g*BOOST_STRIDE +: BOOST_W]),
                .o_standby(o_lane_standby[g]),
                .o_present(present[g]),
                .o_rise(rise[g]),
                .o_fall(fall[g])
            );
            assign eff_boost[g*BOOST_STRIDE+BOOST_W] = 1'b0;
        end
    endgenerate

    assign o_lane0_signal_present = present[0];
    assign o_lane1_signal_present = present[1];
    assign o_lane2_signal_present = present[2];
    assign o_lane3_signal_present = present[3];
    assign o_lane0_boost = eff_boost[0*BOOST_STRIDE +: BOOST_W];
    assign o_lane1_boost = eff_boost[1*BOOST_STRIDE +: BOOST_W];
    assign o_lane2_boost = eff_boost[2*BOOST_STRIDE +: BOOST_W];
    assign o_lane3_boost = eff_boost[3*BOOST_STRIDE +: BOOST_W];

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // one wait state: pready rises on the second access cycle
    wire access = i_psel & i_penable;
    wire fire = access & ready_q & i_clk_en;
    wire sel_boost = (i_paddr == ADDR_BOOST);
    wire sel_status = (i_paddr == ADDR_STATUS);
    wire sel_stat = (i_paddr == ADDR_IRQ_STAT);
    wire sel_mask = (i_paddr == ADDR_IRQ_MASK);
    wire mapped = sel_boost | sel_status | sel_stat | sel_mask;
    wire boost_refused = sel_boost & ~i_reg_access_sel;
    wire bad_access = ~mapped | boost_refused | (sel_status & i_pwrite);
    wire wr_boost = fire & i_pwrite & sel_boost & i_reg_access_sel;
    wire wr_stat = fire & i_pwrite & sel_stat;
    wire wr_mask = fire & i_pwrite & sel_mask;

    wire [31:0] status_word = {
        eff_boost,
        1'b0, pin_boost,
        2'b00, i_reg_access_sel, force_pin,
        present,
        ~o_lane_standby
    };
    wire [31:0] rd_mux =
        (sel_boost & i_reg_access_sel) ? {16'h0000, boost_reg_q} :
        sel_status ? status_word :
        sel_stat ? {24'h000000, irq_stat_q} :
        sel_mask ? {24'h000000, irq_mask_q} :
        32'h0000_0000;

    wire [2*NUM_LANES-1:0] events = {fall, rise};
    wire [2*NUM_LANES-1:0] stat_clr = wr_stat ? i_pwdata[2*NUM_LANES-1:0] : '0;
    // a new event beats a simultaneous write-one-to-clear
    wire [2*NUM_LANES-1:0] stat_d = (irq_stat_q & ~stat_clr) | events;

    // only the valid field bits of the boost word are writable
    wire [NUM_LANES*BOOST_STRIDE-1:0] boost_wmask = {NUM_LANES{4'h7}};
    wire [NUM_LANES*BOOST_STRIDE-1:0] boost_wdata =
        i_pwdata[NUM_LANES*BOOST_STRIDE-1:0] & boost_wmask;

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (i_clk_en) begin
            ready_q <= access & ~ready_q;
            if (access & ~ready_q) prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_reg_q <= {NUM_LANES{1'b0, BOOST_RESET}};
        end else if (wr_boost) begin
            boost_reg_q <= boost_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RESET;
        end else if (i_clk_en) begin
            irq_stat_q <= stat_d;
            if (wr_mask) irq_mask_q <= i_pwdata[2*NUM_LANES-1:0];
        end
    end

    assign o_pready = ready_q;
    assign o_prdata = prdata_q;
    assign o_pslverr = ready_q & bad_access;
    assign o_irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_pin_mode_common: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $past(rst_n) && $past(i_clk_en) && $past(force_pin) |->
        o_lane0_boost == $past(pin_boost) && o_lane1_boost == $past(pin_boost) &&
        o_lane2_boost == $past(pin_boost) && o_lane3_boost == $past(pin_boost))
        else $error("lanes differ from pin boost in pin mode");

    a_reg_mode_lane: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $past(rst_n) && $past(i_clk_en) && !$past(force_pin) |->
        o_lane2_boost == $past(boost_reg_q[2*BOOST_STRIDE +: BOOST_W]))
        else $error("lane boost not from register in register mode");

    a_force_default: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        !i_force_pin_boost_drv |-> force_pin)
        else $error("undriven force pin not seen as high");

    a_select_default: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_boost_level_select_drv == 3'h0 |-> pin_boost == 3'h4)
        else $error("undriven select pins not seen as default");

    a_enable_default: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && !i_lane_active_drv[1] ##1 i_clk_en |-> !o_lane_standby[1])
        else $error("undriven lane enable put lane in standby");

    a_access_refused: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        fire && i_pwrite && sel_boost && !i_reg_access_sel |=> $stable(boost_reg_q))
        else $error("boost register written while access disabled");

    a_refused_error: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_pready && i_psel && sel_boost && !i_reg_access_sel |-> o_pslverr)
        else $error("refused boost access without error");

    a_apb_answer: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && access && !ready_q ##1 i_clk_en |-> o_pready)
        else $error("apb answer not one cycle after access");

    a_event_wins: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && rise[0] |=> irq_stat_q[IRQ_RISE_POS])
        else $error("rise event lost");

    a_lanes_independent: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $past(i_clk_en) |-> present == $past(i_lane_detect_raw))
        else $error("lane detect outputs coupled");

    a_boost_range: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        wr_boost |=> boost_reg_q[BOOST_STRIDE-1] == 1'b0)
        else $error("boost field exceeds three bits");
endmodule

// ### tb/qelc_far_end.sv
`timescale 1ns/100ps
module qelc_far_end (
    input wire logic [3:0] i_activity,
    input wire logic i_loop,
    input wire logic [3:0] i_present,
    input wire logic [3:0] i_enable,
    output logic [3:0] o_detect_raw,
    output logic [3:0] o_active
);
    // detector result per lane; the bench moves it only just after a clock edge
    assign o_detect_raw = i_activity;
    // loop-back: a lane sleeps once its own activity is gone
    assign o_active = i_loop ? i_present : i_enable;
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import qelc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic force_pin = 1'b1;
    logic force_drv = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [2:0] sel_drv = 3'h0;
    logic [3:0] act = 4'hF;
    logic [3:0] act_drv = 4'hF;
    logic [3:0] activity = 4'h0;
    logic loop_on = 1'b0;
    logic acc_sel = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic err;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [3:0] raw, far_act, present, standby;
    wire [2:0] b0, b1, b2, b3;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 32'h7F6BD9C5;

    always #50 clk = ~clk;

    qelc_far_end far (.i_activity(activity), .i_loop(loop_on), .i_present(present),
        .i_enable(act), .o_detect_raw(raw), .o_active(far_act));

    qelc_top dut (.i_core_clk(clk), .i_resetn(rst_n), .i_clk_en(clk_en),
        .i_force_pin_boost(force_pin), .i_force_pin_boost_drv(force_drv),
        .i_boost_level_select(sel), .i_boost_level_select_drv(sel_drv),
        .i_lane0_active_in(far_act[0]), .i_lane1_active_in(far_act[1]),
        .i_lane2_active_in(far_act[2]), .i_lane3_active_in(far_act[3]),
        .i_lane_active_drv(act_drv), .i_lane_detect_raw(raw), .i_reg_access_sel(acc_sel),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_lane0_signal_present(present[0]), .o_lane1_signal_present(present[1]),
        .o_lane2_signal_present(present[2]), .o_lane3_signal_present(present[3]),
        .o_lane0_boost(b0), .o_lane1_boost(b1), .o_lane2_boost(b2), .o_lane3_boost(b3),
        .o_lane_standby(standby), .o_irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(posedge clk);
    endtask

    // one gap edge first so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        // no assumed latency: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // undriven select bits fall back to top bit high, lower bits low
    function automatic logic [2:0] pin_boost(input logic [2:0] v, input logic [2:0] d);
        return (v & d) | (3'h4 & ~d);
    endfunction

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] e;
        logic [31:0] w;
        logic [3:0] ea;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_n(3);
        check({b3, b2, b1, b0}, 12'h924);
        check(standby, 4'h0);
        check(present, 4'h0);
        apb(1'b0, ADDR_BOOST, 32'h0);
        check(rd, 32'h4444);
        $display("test reset done");
        // register values that differ per lane must be ignored in pin mode
        apb(1'b1, ADDR_BOOST, 32'h1357);
        for (int i = 0; i < 16; i++) begin
            force_drv <= i[0];
            force_pin <= i[0] ? 1'b1 : 1'($random(seed));
            sel <= (i < 8) ? i[2:0] : 3'($random(seed));
            sel_drv <= (i < 8) ? 3'h7 : 3'($random(seed));
            wait_n(3);
            e = pin_boost(sel, sel_drv);
            check({b3, b2, b1, b0}, {e, e, e, e});
        end
        $display("test pin boost done");
        force_drv <= 1'b1;
        force_pin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $random(seed);
            apb(1'b1, ADDR_BOOST, w);
            apb(1'b0, ADDR_BOOST, 32'h0);
            check(rd, w & 32'h7777);
            wait_n(2);
            check({b3, b2, b1, b0}, {w[14:12], w[10:8], w[6:4], w[2:0]});
        end
        $display("test register boost done");
        acc_sel <= 1'b0;
        apb(1'b1, ADDR_BOOST, 32'h0);
        check(err, 1'b1);
        apb(1'b0, ADDR_BOOST, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h0);
        check(err, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        check(err, 1'b1);
        acc_sel <= 1'b1;
        apb(1'b0, ADDR_BOOST, 32'h0);
        check(err, 1'b0);
        check(rd, w & 32'h7777);
        $display("test access refusal done");
        for (int i = 0; i < 12; i++) begin
            act <= 4'($random(seed));
            act_drv <= (i < 4) ? 4'hF : 4'($random(seed));
            wait_n(3);
            ea = act | ~act_drv;
            check(standby, {~ea});
        end
        act <= 4'hF;
        act_drv <= 4'hF;
        $display("test enables done");
        for (int i = 0; i < 8; i++) begin
            activity <= 4'($random(seed));
            wait_n(3);
            check(present, activity);
        end
        activity <= 4'h0;
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, ADDR_IRQ_STAT, 32'hFF);
        wait_n(2);
        check(irq, 1'b0);
        activity <= 4'h1;
        wait_n(3);
        check(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        wait_n(2);
        check(irq, 1'b0);
        activity <= 4'h0;
        wait_n(3);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check({irq, rd[4]}, 2'b01);
        $display("test detect irq done");
        // loop-back: idle lanes fall asleep, active ones wake
        loop_on <= 1'b1;
        activity <= 4'hA;
        wait_n(4);
        check(standby, 4'h5);
        activity <= 4'h5;
        wait_n(4);
        check({present, standby}, 8'h5A);
        $display("test loop back done");
        // enable low: outputs hold although activity changes
        clk_en <= 1'b0;
        activity <= 4'hA;
        wait_n(3);
        check({present, standby}, 8'h5A);
        clk_en <= 1'b1;
        wait_n(4);
        check({present, standby}, 8'hA5);
        $display("test clock enable done");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, {w[15:0] & 16'h7777, 1'b0, pin_boost(sel, sel_drv), 4'h2, 8'hAA});
        $display("test status done");
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        final_report;
    end
endmodule
